/* design/fhe_pkg.sv */
// Package for the frame FFT engine: sizes, reset values, counters, tables.
// Assumes a single clock domain and that all design files import it whole.
//
// Functional notes
// - Forward or inverse radix-2 DIT transform, N a power of two, 32..2048.
// - Samples are b-bit two's-complement real and imaginary parts, b 8..16.
// - Each burst of N accepted samples forms one transform job.
// - After the last stage the full result leaves in natural order.
// - A second input bank loads while the other computes and outputs.
// - Low reset clears all control state and buffer bookkeeping.
// - After reset release, twiddle lookup RAM is filled before any input.
// - Initialization ends in the ready state without host action.
// - Start high after initialization returns the engine to ready.
// - Start high discards everything held in input and output buffers.
// - A high input valid captures both input buses as one sample.
// - A full input bank starts processing with no further command.
// - Accept drops as soon as N samples of the burst are stored.
// - Accept rises again once an input bank is free.
// - Without input valid the buses are ignored and no count advances.
// - Results are stored in the output buffer, then available goes high.
// - Output valid marks each cycle the output buses carry a result.
// - Output samples are sent only in the cycle after sink ready is seen high.
// - While sink ready is low, undelivered results are kept, none lost.
// - Bank ping-pong is internal; host sees one ready or busy buffer.
`default_nettype none

package fhe_pkg;

  // Transform length and sample width limits and defaults.
  localparam int FHE_N_MIN       = 32;
  localparam int FHE_N_MAX       = 2048;
  localparam int FHE_N_DEFAULT   = 256;
  localparam int FHE_B_MIN       = 8;
  localparam int FHE_B_MAX       = 16;
  localparam int FHE_B_DEFAULT   = 16;

  // Depth of the staging FIFO in front of the output pins.
  localparam int FHE_FIFO_DEPTH  = 8;

  // Width of the stage counter; eleven stages fit for the largest length.
  localparam int FHE_STAGE_W     = 4;

  // Reset values of the control flags.
  localparam logic FHE_FLAG_RESET     = 1'b0;
  localparam logic FHE_BANK_SEL_RESET = 1'b0;

  // Twiddle generator: CORDIC with angles as fractions of 2**32.
  localparam int FHE_CORDIC_ITER = 16;
  localparam int FHE_CORDIC_FRAC = 30;
  localparam logic signed [33:0] FHE_CORDIC_GAIN = 34'h026DD3B6A;
  localparam logic [31:0] FHE_QUARTER_TURN = 32'h40000000;
  localparam logic [31:0] FHE_CORDIC_ATAN [FHE_CORDIC_ITER] = '{
    32'h20000000, 32'h12E4051E, 32'h09FB385B, 32'h051111D4,
    32'h028B0D43, 32'h0145D7E1, 32'h00A2F61E, 32'h00517C55,
    32'h0028BE53, 32'h00145F2F, 32'h000A2F98, 32'h000517CC,
    32'h00028BE6, 32'h000145F3, 32'h0000A2FA, 32'h0000517D
  };

  // Power-up sequencing of the lookup tables.
  typedef enum logic {
    FHE_S_INIT,
    FHE_S_READY
  } fhe_init_state_type;

  // Transform engine sequencing.
  typedef enum logic [1:0] {
    FHE_E_IDLE,
    FHE_E_BFLY,
    FHE_E_COPY
  } fhe_eng_state_type;

endpackage

`default_nettype wire

/* design/fhe_fifo.sv */
// Small synchronous FIFO that stages results ahead of the output pins.
// Assumes one clock, DEPTH a power of two, and a flush held for one cycle.
`timescale 1ns/10ps
`default_nettype none

module fhe_fifo import fhe_pkg::*; #(
  parameter int WIDTH = 32,
  parameter int DEPTH = FHE_FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////////
  // Full and empty come from pointers carrying one wrap bit each.
  assign in_ready_o  = !((wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                         (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
  assign out_valid_o = (wr_ptr_q != rd_ptr_q);
  assign out_data_o  = mem[rd_ptr_q[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;

  ////////////////////////////////////////////////////////////////////////////
  // Storage needs no reset; only words between the pointers are ever read.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data_i;
    end
  end

  // Pointer update; a flush empties the queue at once.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (flush_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* design/fhe_top.sv */
// Frame FFT engine with ping-pong input banks and a buffered result stream.
// Assumes synchronous host inputs, one clock, and N a power of two.
`timescale 1ns/10ps
`default_nettype none

module fhe_top import fhe_pkg::*; #(
  parameter int N          = FHE_N_DEFAULT,
  parameter int B          = FHE_B_DEFAULT,
  parameter int FIFO_DEPTH = FHE_FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         start_i,
  input  wire logic         inverse_i,
  input  wire logic         in_valid_i,
  input  wire logic [B-1:0] in_re_i,
  input  wire logic [B-1:0] in_im_i,
  output logic              in_accept_o,
  output logic              ready_o,
  output logic              results_avail_o,
  input  wire logic         sink_ready_i,
  output logic              out_valid_o,
  output logic      [B-1:0] out_re_o,
  output logic      [B-1:0] out_im_o
);

  localparam int LOG2N = $clog2(N);
  localparam int HALF  = N / 2;
  localparam logic [LOG2N-1:0] LAST_SAMPLE = LOG2N'(N - 1);
  localparam logic [LOG2N-2:0] LAST_BFLY   = (LOG2N-1)'(HALF - 1);
  localparam logic [FHE_STAGE_W-1:0] LAST_STAGE = FHE_STAGE_W'(LOG2N - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Saturate a wide signed value to b bits, symmetric so it negates safely.
  function automatic logic signed [B-1:0] fhe_sat(
    input logic signed [33:0] v
  );
    logic signed [33:0] lim;
    lim = 34'((1 << (B - 1)) - 1);
    if (v > lim) begin
      return B'(lim);
    end else if (v < -lim) begin
      return B'(-lim);
    end
    return B'(v);
  endfunction

  // Cosine and sine of 2*pi*k/N by an unrolled CORDIC, packed {cos, sin}.
  function automatic logic [2*B-1:0] fhe_twiddle(
    input logic [LOG2N-2:0] k
  );
    logic signed [33:0] x;
    logic signed [33:0] y;
    logic signed [33:0] z;
    logic signed [33:0] xn;
    logic        [31:0] ang;
    logic               rot;
    logic signed [B-1:0] cs;
    logic signed [B-1:0] sn;
    ang = 32'(k) << (32 - LOG2N);
    rot = (ang >= FHE_QUARTER_TURN);
    if (rot) begin
      ang = ang - FHE_QUARTER_TURN;
    end
    x = FHE_CORDIC_GAIN;
    y = '0;
    z = $signed({2'b00, ang});
    for (int i = 0; i < FHE_CORDIC_ITER; i++) begin
      if (z >= 0) begin
        xn = x - (y >>> i);
        y  = y + (x >>> i);
        z  = z - $signed({2'b00, FHE_CORDIC_ATAN[i]});
      end else begin
        xn = x + (y >>> i);
        y  = y - (x >>> i);
        z  = z + $signed({2'b00, FHE_CORDIC_ATAN[i]});
      end
      x = xn;
    end
    cs = fhe_sat(x >>> (FHE_CORDIC_FRAC - (B - 1)));
    sn = fhe_sat(y >>> (FHE_CORDIC_FRAC - (B - 1)));
    // Second quadrant folds onto the first by a quarter turn.
    if (rot) begin
      return {B'(-sn), cs};
    end
    return {cs, sn};
  endfunction

  // Bit-reversed address, so DIT stages leave results in natural order.
  function automatic logic [LOG2N-1:0] fhe_bitrev(
    input logic [LOG2N-1:0] a
  );
    logic [LOG2N-1:0] r;
    r = '0;
    for (int i = 0; i < LOG2N; i++) begin
      r[i] = a[LOG2N-1-i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Memories: two input banks, the output buffer and the twiddle tables.
  logic signed [B-1:0] bank_re [2][N];
  logic signed [B-1:0] bank_im [2][N];
  logic signed [B-1:0] obuf_re [N];
  logic signed [B-1:0] obuf_im [N];
  logic signed [B-1:0] tw_cos  [HALF];
  logic signed [B-1:0] tw_sin  [HALF];

  fhe_init_state_type     init_q;
  fhe_eng_state_type      eng_q;
  logic [LOG2N-2:0]       tw_idx_q;
  logic [1:0]             full_q;
  logic [1:0]             full_d;
  logic                   fill_bank_q;
  logic                   fill_bank_d;
  logic [LOG2N-1:0]       fill_cnt_q;
  logic [FHE_STAGE_W-1:0] stage_q;
  logic [LOG2N-2:0]       bfly_q;
  logic [LOG2N-1:0]       cp_cnt_q;
  logic                   inv_q;
  logic                   out_avail_q;
  logic [LOG2N-1:0]       rd_ptr_q;
  logic                   accept_q;
  logic                   ready_q;
  logic                   avail_q;
  logic                   out_valid_q;
  logic [B-1:0]           out_re_q;
  logic [B-1:0]           out_im_q;
  logic                   restart;
  logic                   take;
  logic                   fill_last;
  logic                   copy_go;
  logic                   copy_last;
  logic                   push_ready;
  logic                   fifo_valid;
  logic [2*B-1:0]         fifo_data;
  logic                   pop;
  logic                   eng_bank;
  logic [LOG2N-1:0]       top_a;
  logic [LOG2N-1:0]       bot_a;
  logic [LOG2N-2:0]       tw_a;
  logic signed [B-1:0]    wr;
  logic signed [B-1:0]    wi;
  logic signed [B-1:0]    top_re;
  logic signed [B-1:0]    top_im;
  logic signed [B-1:0]    bot_re;
  logic signed [B-1:0]    bot_im;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer qualifiers shared by the control processes.
  assign restart   = start_i && (init_q == FHE_S_READY);
  assign take      = in_valid_i && accept_q && !restart;
  assign fill_last = take && (fill_cnt_q == LAST_SAMPLE);
  assign copy_go   = (eng_q == FHE_E_COPY) && !out_avail_q;
  assign copy_last = copy_go && (cp_cnt_q == LAST_SAMPLE);
  assign eng_bank  = ~fill_bank_q;
  assign pop       = sink_ready_i && fifo_valid && !restart;

  // Bank bookkeeping; the filling bank only moves onto an empty bank.
  always_comb begin
    full_d      = full_q;
    fill_bank_d = fill_bank_q;
    if (full_q[fill_bank_q] && !full_q[eng_bank]) begin
      fill_bank_d = eng_bank;
    end
    if (fill_last) begin
      full_d[fill_bank_q] = 1'b1;
    end
    if (copy_last) begin
      full_d[eng_bank] = 1'b0;
    end
    if (restart) begin
      full_d      = '0;
      fill_bank_d = FHE_BANK_SEL_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up: fill the twiddle RAM, then go ready on our own.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_q   <= FHE_S_INIT;
      tw_idx_q <= '0;
    end else if (init_q == FHE_S_INIT) begin
      tw_idx_q <= tw_idx_q + 1'b1;
      if (tw_idx_q == LAST_BFLY) begin
        init_q <= FHE_S_READY;
      end
    end
  end

  // Twiddle RAM writes; the CORDIC is only exercised during power-up.
  always_ff @(posedge clk_i) begin
    if (init_q == FHE_S_INIT) begin
      {tw_cos[tw_idx_q], tw_sin[tw_idx_q]} <= fhe_twiddle(tw_idx_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input side: sample count, bank flags and the accept flag.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      full_q      <= '0;
      fill_bank_q <= FHE_BANK_SEL_RESET;
      fill_cnt_q  <= '0;
      accept_q    <= FHE_FLAG_RESET;
    end else begin
      full_q      <= full_d;
      fill_bank_q <= fill_bank_d;
      if (restart) begin
        fill_cnt_q <= '0;
      end else if (take) begin
        fill_cnt_q <= fill_cnt_q + 1'b1;
      end
      // Low for the burst's end and while both banks hold frames.
      accept_q <= (init_q == FHE_S_READY) && !restart &&
                  !full_d[fill_bank_d];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine sequencing: one butterfly per clock, stages in order, then copy.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      eng_q    <= FHE_E_IDLE;
      stage_q  <= '0;
      bfly_q   <= '0;
      cp_cnt_q <= '0;
      inv_q    <= FHE_FLAG_RESET;
    end else if (restart) begin
      eng_q <= FHE_E_IDLE;
    end else begin
      unique case (eng_q)
        FHE_E_IDLE: begin
          if ((init_q == FHE_S_READY) && full_q[eng_bank]) begin
            eng_q   <= FHE_E_BFLY;
            stage_q <= '0;
            bfly_q  <= '0;
            inv_q   <= inverse_i;
          end
        end
        FHE_E_BFLY: begin
          bfly_q <= bfly_q + 1'b1;
          if (bfly_q == LAST_BFLY) begin
            if (stage_q == LAST_STAGE) begin
              eng_q    <= FHE_E_COPY;
              cp_cnt_q <= '0;
            end else begin
              stage_q <= stage_q + 1'b1;
            end
          end
        end
        FHE_E_COPY: begin
          if (copy_go) begin
            cp_cnt_q <= cp_cnt_q + 1'b1;
            if (copy_last) begin
              eng_q <= FHE_E_IDLE;
            end
          end
        end
        // The fourth code is never entered; recover to idle if it appears.
        default: begin
          eng_q <= FHE_E_IDLE;
        end
      endcase
    end
  end

  // Butterfly addressing and arithmetic, scaled by one half per stage.
  always_comb begin
    int unsigned grp;
    int unsigned pos;
    logic signed [2*B:0] pr;
    logic signed [2*B:0] pi;
    logic signed [33:0]  tr;
    logic signed [33:0]  ti;
    logic signed [B-1:0] ar;
    logic signed [B-1:0] ai;
    logic signed [B-1:0] br;
    logic signed [B-1:0] bi;
    grp   = 32'(bfly_q) >> stage_q;
    pos   = 32'(bfly_q) & ((32'd1 << stage_q) - 32'd1);
    top_a = LOG2N'((grp << (stage_q + 1)) + pos);
    bot_a = LOG2N'((grp << (stage_q + 1)) + pos + (32'd1 << stage_q));
    tw_a  = (LOG2N-1)'(pos << (LOG2N - 1 - stage_q));
    // Forward uses the conjugate twiddle; inverse uses it as stored.
    wr    = tw_cos[tw_a];
    wi    = inv_q ? tw_sin[tw_a] : B'(-tw_sin[tw_a]);
    ar    = bank_re[eng_bank][top_a];
    ai    = bank_im[eng_bank][top_a];
    br    = bank_re[eng_bank][bot_a];
    bi    = bank_im[eng_bank][bot_a];
    pr    = (2*B+1)'(wr) * (2*B+1)'(br) - (2*B+1)'(wi) * (2*B+1)'(bi);
    pi    = (2*B+1)'(wr) * (2*B+1)'(bi) + (2*B+1)'(wi) * (2*B+1)'(br);
    tr    = 34'(pr >>> (B - 1));
    ti    = 34'(pi >>> (B - 1));
    top_re = fhe_sat((34'(ar) + tr) >>> 1);
    top_im = fhe_sat((34'(ai) + ti) >>> 1);
    bot_re = fhe_sat((34'(ar) - tr) >>> 1);
    bot_im = fhe_sat((34'(ai) - ti) >>> 1);
  end

  // Bank writes; loading and computing never share a bank.
  always_ff @(posedge clk_i) begin
    if (take) begin
      bank_re[fill_bank_q][fhe_bitrev(fill_cnt_q)] <= in_re_i;
      bank_im[fill_bank_q][fhe_bitrev(fill_cnt_q)] <= in_im_i;
    end
    if (eng_q == FHE_E_BFLY) begin
      bank_re[eng_bank][top_a] <= top_re;
      bank_im[eng_bank][top_a] <= top_im;
      bank_re[eng_bank][bot_a] <= bot_re;
      bank_im[eng_bank][bot_a] <= bot_im;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output buffer: loaded whole from the bank, then streamed in index order.
  always_ff @(posedge clk_i) begin
    if (copy_go) begin
      obuf_re[cp_cnt_q] <= bank_re[eng_bank][cp_cnt_q];
      obuf_im[cp_cnt_q] <= bank_im[eng_bank][cp_cnt_q];
    end
  end

  // The copy waits until the previous frame has left the output buffer.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_avail_q <= FHE_FLAG_RESET;
      rd_ptr_q    <= '0;
    end else if (restart) begin
      out_avail_q <= FHE_FLAG_RESET;
      rd_ptr_q    <= '0;
    end else if (copy_last) begin
      out_avail_q <= 1'b1;
      rd_ptr_q    <= '0;
    end else if (out_avail_q && push_ready) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
      if (rd_ptr_q == LAST_SAMPLE) begin
        out_avail_q <= FHE_FLAG_RESET;
      end
    end
  end

  // The FIFO stalls the buffer read once it fills while the sink holds back.
  fhe_fifo #(
    .WIDTH (2 * B),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .flush_i     (restart),
    .in_valid_i  (out_avail_q),
    .in_ready_o  (push_ready),
    .in_data_i   ({obuf_re[rd_ptr_q], obuf_im[rd_ptr_q]}),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered pins: one result per clock, only after sink ready was seen.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_valid_q <= FHE_FLAG_RESET;
      out_re_q    <= '0;
      out_im_q    <= '0;
      avail_q     <= FHE_FLAG_RESET;
      ready_q     <= FHE_FLAG_RESET;
    end else begin
      out_valid_q <= pop;
      if (pop) begin
        {out_re_q, out_im_q} <= fifo_data;
      end
      avail_q <= !restart && (out_avail_q || fifo_valid);
      ready_q <= (init_q == FHE_S_READY);
    end
  end

  assign in_accept_o     = accept_q;
  assign ready_o         = ready_q;
  assign results_avail_o = avail_q;
  assign out_valid_o     = out_valid_q;
  assign out_re_o        = out_re_q;
  assign out_im_o        = out_im_q;

endmodule

`default_nettype wire

/* dv/fhe_sva.sv */
// Checker for the host-side ports of the frame FFT engine.
// Assumes one clock and a bind onto fhe_top that passes N and B on.
`timescale 1ns/10ps
`default_nettype none
module fhe_sva import fhe_pkg::*; #(
  parameter int N = FHE_N_DEFAULT,
  parameter int B = FHE_B_DEFAULT
) (
  input wire logic         clk_i,
  input wire logic         resetn_i,
  input wire logic         start_i,
  input wire logic         in_valid_i,
  input wire logic         in_accept_o,
  input wire logic         ready_o,
  input wire logic         results_avail_o,
  input wire logic         sink_ready_i,
  input wire logic         out_valid_o,
  input wire logic [B-1:0] out_re_o,
  input wire logic [B-1:0] out_im_o
);
  logic [11:0] fc_q;
  logic [11:0] ic_q;
  logic        take;
  ////////////////////////////////////////
  // A sample counts only with accept high and no restart beside it.
  assign take = in_valid_i && in_accept_o && !start_i;
  // Samples of the current burst; a restart empties the burst.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) fc_q <= '0;
    else if (start_i && ready_o) fc_q <= '0;
    else if (take) fc_q <= (fc_q == 12'(N - 1)) ? '0 : fc_q + 12'h001;
  end
  // Cycles before ready; it saturates so a stuck init cannot wrap.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) ic_q <= '0;
    else if (!ready_o && ic_q != 12'hFFF) ic_q <= ic_q + 12'h001;
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_init_length: assert property ($rose(ready_o)
    |-> ic_q == 12'(N / 2 + 1)) else $error("Ready rose at a wrong time.");
  a_accept_init: assert property (!ready_o |-> !in_accept_o)
    else $error("Accept high before ready.");
  a_ready_holds: assert property (ready_o |=> ready_o)
    else $error("Ready was lost.");
  a_quiet_init: assert property (!ready_o
    |-> !out_valid_o && !results_avail_o) else $error("Output in init.");
  a_accept_drop: assert property (take && fc_q == 12'(N - 1)
    |=> !in_accept_o) else $error("Accept stayed high after a frame.");
  a_start_flush: assert property (start_i && ready_o
    |=> !in_accept_o && !out_valid_o) else $error("Restart not flushed.");
  a_out_paced: assert property (out_valid_o |-> $past(sink_ready_i))
    else $error("Output without sink ready.");
  a_data_hold: assert property (!out_valid_o && !$past(start_i)
    |-> $stable(out_re_o) && $stable(out_im_o)) else $error("Data moved.");
  c_frame_end: cover property (take && fc_q == 12'(N - 1));
  c_out_beat: cover property (out_valid_o && sink_ready_i);
  c_restart: cover property (start_i && ready_o);
endmodule
`default_nettype wire

/* dv/fhe_sink_model.sv */
// Result-receiving host: it alone sets the pace of the output stream.
// Assumes the bench raises stall_i to hold it back for long spans.
`timescale 1ns/10ps
`default_nettype none
module fhe_sink_model (
  input  wire logic clk_i,
  input  wire logic stall_i,
  output logic      sink_ready_o
);
  logic rdy_q = 1'b0;
  // Ready drops at random, so the engine must keep every word it holds.
  always @(posedge clk_i) begin
    rdy_q <= #1 stall_i ? 1'b0 : 1'($urandom_range(0, 2) != 0);
  end
  assign sink_ready_o = rdy_q;
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for fhe_top with tone frames in both directions.
// Assumes the checker and sink model files are compiled beforehand.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int N = 32;
  localparam int B = 16;
  logic           clk_i      = 1'b0;
  logic           resetn_i   = 1'b0;
  logic           start_i    = 1'b0;
  logic           inverse_i  = 1'b0;
  logic           in_valid_i = 1'b0;
  logic [B-1:0]   in_re_i    = '0;
  logic [B-1:0]   in_im_i    = '0;
  logic           stall      = 1'b1;
  logic           in_accept_o, ready_o, results_avail_o;
  logic           sink_ready_i, out_valid_o;
  logic [B-1:0]   out_re_o, out_im_o;
  logic [2*B-1:0] exp_q[$];
  logic [2*B-1:0] e;
  int             mismatches = 0;
  int             tests_run  = 0;
  int             w;
  always #2.5 clk_i = ~clk_i;
  fhe_top #(.N(N), .B(B)) fhe_top_i (.clk_i, .resetn_i, .start_i, .inverse_i,
    .in_valid_i, .in_re_i, .in_im_i, .in_accept_o, .ready_o, .results_avail_o,
    .sink_ready_i, .out_valid_o, .out_re_o, .out_im_o);
  fhe_sink_model fhe_sink_model_i (.clk_i, .stall_i(stall),
    .sink_ready_o(sink_ready_i));
  ////////////////////////////////////////
  // Counts every compare and reports a difference at once.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  // Twiddle rounding costs a few LSB, so results match within a margin.
  function automatic logic near(input logic [B-1:0] s, input logic [B-1:0] x);
    int d;
    d = $signed(s) - $signed(x);
    return (^s !== 1'bx) && d <= 8 && d >= -8;
  endfunction
  function automatic logic [B-1:0] rnd();
    return B'($urandom_range(0, 16'h1F40)) - 16'h0FA0;
  endfunction
  // Holds one sample until the edge that finds accept high.
  task put(input logic [B-1:0] re, input logic [B-1:0] im);
    in_valid_i = 1'b1;
    in_re_i = re;
    in_im_i = im;
    do @(posedge clk_i); while (in_accept_o !== 1'b1);
    #1;
  endtask
  // A quarter-turn tone lands in bin N/4, or in bin 3N/4 when inverse.
  task frame(input logic inv, input int cnt, input bit flip);
    logic [B-1:0] re, im, t;
    re = rnd();
    im = rnd();
    for (int i = 0; i < cnt; i++) begin
      if (i == 4) inverse_i = inv;
      put(re, im);
      t = re;
      re = -im;
      im = t;
      if ($urandom_range(0, 3) == 0 && i < cnt - 1) begin
        in_valid_i = 1'b0;
        @(posedge clk_i);
        #1;
      end
    end
    if (cnt < N) begin
      in_valid_i = 1'b0;
      return;
    end
    in_re_i = 16'h7FFF;
    @(posedge clk_i);
    #1;
    in_valid_i = 1'b0;
    for (int k = 0; k < N; k++) begin
      exp_q.push_back((k == (inv ? 3 * N / 4 : N / 4)) ? {re, im} : '0);
    end
    w = 0;
    while (in_accept_o !== 1'b1 && w < 900) begin
      @(posedge clk_i);
      #1;
      w++;
    end
    check(flip ? w <= 1 : w < 900, 1);
  endtask
  task drain();
    w = 0;
    while (exp_q.size() != 0 && w < 4000) begin
      @(posedge clk_i);
      #1;
      w++;
    end
    check(exp_q.size(), 0);
    repeat (4) @(posedge clk_i);
    check(results_avail_o, 0);
  endtask
  task stop_test();
    $display("Compares %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Each result beat is matched against the oldest expected word.
  always @(posedge clk_i) begin
    if (out_valid_o === 1'b1) begin
      check(exp_q.size() != 0, 1);
      if (exp_q.size() != 0) begin
        e = exp_q.pop_front();
        check(near(out_re_o, e[2*B-1:B]) && near(out_im_o, e[B-1:0]), 1);
      end
    end
  end
  // Junk refused while accept is low would shift a frame visibly.
  initial begin
    void'($urandom(2170));
    repeat (16) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    w = 0;
    while (ready_o !== 1'b1 && w < 900) begin
      @(posedge clk_i);
      #1;
      w++;
    end
    check(w, N / 2 + 1);
    check(in_accept_o, 1);
    frame(1'b0, N, 1'b1);
    frame(1'b1, N, 1'b0);
    repeat (300) @(posedge clk_i);
    check(results_avail_o, 1);
    #1;
    stall = 1'b0;
    frame(1'b0, N, 1'b0);
    drain();
    frame(1'b1, N / 2, 1'b0);
    start_i = 1'b1;
    @(posedge clk_i);
    #1;
    start_i = 1'b0;
    check(in_accept_o, 0);
    frame(1'b1, N, 1'b0);
    drain();
    stop_test();
  end
  initial begin
    #60000;
    mismatches++;
    stop_test();
  end
endmodule
bind fhe_top fhe_sva #(.N(N), .B(B)) fhe_sva_i (.clk_i, .resetn_i, .start_i,
  .in_valid_i, .in_accept_o, .ready_o, .results_avail_o, .sink_ready_i,
  .out_valid_o, .out_re_o, .out_im_o);
`default_nettype wire
